/* File: rtl/adc_mode_control_regs_low.sv */
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Address 00h holds the soft reset trigger in bit 7; bits 6-0 unused.
// - Writing one to bit 7 of address 00h clears every mode-control bit.
// - The reset trigger clears itself once the reset has been applied.
// - Unused bit positions always read back as zero.
// - Address 02h has no bits: it reads zero and writes are dropped.
// - Address 03h holds encode term, keep-alive, invert, phase, stabilizer.
// - Keep-alive oscillator bit resets to zero (running); one disables it.
// - Output clock invert resets to zero (normal); one inverts the clock.
// - Output clock phase resets to 00, meaning no delay.
// - Phase codes 01, 10, 11 delay the output clock 1/8, 1/4, 3/8 period.
// - Bits 2 and 1 of address 03h form one two-bit phase field.
// - A frame is a read flag, 7-bit address, 8 data bits; low flag writes.
// - A read frame shifts the register out on the serial output unchanged.
module adc_mode_control_regs_low
    import adc_mode_regs_pkg::*;
(
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_ARST_N,
    // Serial port
    input wire logic I_CS_N,
    input wire logic I_SCK,
    input wire logic I_SDI,
    output logic O_SDO_OUT,
    output logic O_SDO_OE,
    // Converter control
    output logic O_FRONT_END_GAIN_SELECT,
    output logic O_DITHER_DISABLE,
    output logic O_POWER_DOWN,
    // Clock control
    output logic O_ENCODE_TERM_ENABLE,
    output logic O_KEEP_ALIVE_OSC_DISABLE,
    output logic O_OUTPUT_CLOCK_INVERT,
    output logic [1:0] O_OUTPUT_CLOCK_PHASE,
    output logic O_DUTY_CYCLE_STABILIZER_ENABLE
);

    logic [2:0] sync_level;
    logic cs_n_s;
    logic sck_s;
    logic sdi_s;
    logic sck_prev_reg;
    logic sck_rise;
    logic sck_fall;
    logic [4:0] bit_cnt_reg;
    logic [14:0] shift_reg;
    logic [15:0] frame;
    logic read_active_reg;
    logic [7:0] rd_shift_reg;
    logic sdo_out_reg;
    logic sdo_oe_reg;
    logic header_done;
    logic wr_now;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
    logic soft_reset_reg;
    logic [7:0] converter_ctrl_reg;
    logic [7:0] clock_ctrl_reg;

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    input_sync #(
        .WIDTH(3),
        .RESET_VAL(3'h1)
    ) u_sync (
        .i_clk(I_CLK),
        .i_arst_n(I_ARST_N),
        .i_async({I_SDI, I_SCK, I_CS_N}),
        .o_level(sync_level)
    );

    assign cs_n_s = sync_level[0];
    assign sck_s = sync_level[1];
    assign sdi_s = sync_level[2];

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            sck_prev_reg <= 1'b0;
        end else begin
            sck_prev_reg <= sck_s;
        end
    end

    assign sck_rise = !cs_n_s && sck_s && !sck_prev_reg;
    assign sck_fall = !cs_n_s && !sck_s && sck_prev_reg;

    // ------------------------------------------------------------
    // Frame capture
    // ------------------------------------------------------------
    assign frame = {shift_reg, sdi_s};
    assign header_done = sck_rise &&
        (bit_cnt_reg == 5'(HEADER_BITS - 1));
    assign wr_now = sck_rise && (bit_cnt_reg == 5'(FRAME_BITS - 1)) &&
        !frame[RW_POS];
    assign wr_addr = frame[RW_POS-1 -: ADDR_BITS];
    assign wr_data = frame[DATA_BITS-1:0];

    // Edges past the sixteenth are ignored
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            bit_cnt_reg <= BIT_CNT_RESET;
            shift_reg <= '0;
        end else if (cs_n_s) begin
            bit_cnt_reg <= BIT_CNT_RESET;
        end else if (sck_rise && bit_cnt_reg < 5'(FRAME_BITS)) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            shift_reg <= frame[14:0];
        end
    end

    // ------------------------------------------------------------
    // Read-back path
    // ------------------------------------------------------------
    function automatic logic [7:0] read_value(input logic [6:0] addr);
        logic [7:0] value;
        value = 8'h00;
        case (addr)
            CONVERTER_CTRL_ADDR: value = converter_ctrl_reg;
            CLOCK_CTRL_ADDR: value = clock_ctrl_reg;
            UNUSED_SLOT_ADDR: value = UNUSED_SLOT_VALUE;
            default: value = 8'h00;
        endcase
        return value;
    endfunction : read_value

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            read_active_reg <= 1'b0;
            rd_shift_reg <= 8'h00;
        end else if (cs_n_s) begin
            read_active_reg <= 1'b0;
        end else if (header_done) begin
            read_active_reg <= frame[HEADER_BITS-1];
            rd_shift_reg <= read_value(frame[ADDR_BITS-1:0]);
        end else if (sck_fall && read_active_reg) begin
            rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
        end
    end

    // Open drain: pull low for a zero data bit, release otherwise
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            sdo_oe_reg <= 1'b0;
            sdo_out_reg <= 1'b0;
        end else if (cs_n_s) begin
            sdo_oe_reg <= 1'b0;
        end else if (sck_fall) begin
            sdo_oe_reg <= read_active_reg &&
                bit_cnt_reg >= 5'(HEADER_BITS) &&
                bit_cnt_reg < 5'(FRAME_BITS) &&
                !rd_shift_reg[7];
        end
    end

    assign O_SDO_OUT = sdo_out_reg;
    assign O_SDO_OE = sdo_oe_reg;

    // ------------------------------------------------------------
    // Mode-control registers
    // ------------------------------------------------------------
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            soft_reset_reg <= 1'b0;
        end else if (soft_reset_reg) begin
            soft_reset_reg <= 1'b0;
        end else if (wr_now && wr_addr == SOFT_RESET_CTRL_ADDR) begin
            soft_reset_reg <= wr_data[SOFT_RESET_POS];
        end
    end

    // Address 02h and unmapped addresses take no write
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            converter_ctrl_reg <= CONVERTER_CTRL_RESET;
            clock_ctrl_reg <= CLOCK_CTRL_RESET;
        end else if (soft_reset_reg) begin
            converter_ctrl_reg <= CONVERTER_CTRL_RESET;
            clock_ctrl_reg <= CLOCK_CTRL_RESET;
        end else if (wr_now && wr_addr == CONVERTER_CTRL_ADDR) begin
            converter_ctrl_reg <= wr_data & CONVERTER_CTRL_MASK;
        end else if (wr_now && wr_addr == CLOCK_CTRL_ADDR) begin
            clock_ctrl_reg <= wr_data & CLOCK_CTRL_MASK;
        end
    end

    assign O_FRONT_END_GAIN_SELECT =
        converter_ctrl_reg[FRONT_END_GAIN_SELECT_POS];
    assign O_DITHER_DISABLE = converter_ctrl_reg[DITHER_DISABLE_POS];
    assign O_POWER_DOWN = converter_ctrl_reg[POWER_DOWN_POS];
    assign O_ENCODE_TERM_ENABLE = clock_ctrl_reg[ENCODE_TERM_ENABLE_POS];
    assign O_KEEP_ALIVE_OSC_DISABLE =
        clock_ctrl_reg[KEEP_ALIVE_OSC_DISABLE_POS];
    assign O_OUTPUT_CLOCK_INVERT =
        clock_ctrl_reg[OUTPUT_CLOCK_INVERT_POS];
    // Code n delays the output clock by n eighths of a period
    assign O_OUTPUT_CLOCK_PHASE = clock_ctrl_reg[OUTPUT_CLOCK_PHASE_HI:
        OUTPUT_CLOCK_PHASE_LO];
    assign O_DUTY_CYCLE_STABILIZER_ENABLE =
        clock_ctrl_reg[DUTY_CYCLE_STABILIZER_POS];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_soft_reset_clear: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        soft_reset_reg |=> (converter_ctrl_reg == 8'h00 &&
            clock_ctrl_reg == 8'h00))
        else $error("soft reset left mode bits set");

    a_trigger_self_clear: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        soft_reset_reg |=> !soft_reset_reg ##1 !soft_reset_reg)
        else $error("reset trigger did not clear");

    a_trigger_cause: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        $rose(soft_reset_reg) |-> $past(wr_now) &&
            $past(wr_addr) == SOFT_RESET_CTRL_ADDR &&
            $past(wr_data[SOFT_RESET_POS]))
        else $error("reset trigger set without a write to 00h");

    a_unused_bits_zero: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        (converter_ctrl_reg & ~CONVERTER_CTRL_MASK) == 8'h00 &&
        (clock_ctrl_reg & ~CLOCK_CTRL_MASK) == 8'h00)
        else $error("unused bit holds a one");

    a_unused_slot_read: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        (header_done && frame[ADDR_BITS-1:0] == UNUSED_SLOT_ADDR) |=>
            rd_shift_reg == 8'h00)
        else $error("address 02h read back non-zero");

    a_clock_write: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        (wr_now && wr_addr == CLOCK_CTRL_ADDR && !soft_reset_reg) |=>
            clock_ctrl_reg == ($past(wr_data) & CLOCK_CTRL_MASK))
        else $error("clock control write lost");

    a_converter_write: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        (wr_now && wr_addr == CONVERTER_CTRL_ADDR && !soft_reset_reg) |=>
            O_POWER_DOWN == $past(wr_data[POWER_DOWN_POS]) &&
            O_DITHER_DISABLE == $past(wr_data[DITHER_DISABLE_POS]))
        else $error("converter control write lost");

    a_read_keeps_regs: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        (!wr_now && !soft_reset_reg) |=> $stable(clock_ctrl_reg) &&
            $stable(converter_ctrl_reg))
        else $error("register changed without a write frame");

    a_sdo_released: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        (cs_n_s || !read_active_reg) |=> !O_SDO_OE)
        else $error("serial output driven outside a read");

    a_phase_field: assert property (
        @(posedge I_CLK) disable iff (!I_ARST_N)
        (wr_now && wr_addr == CLOCK_CTRL_ADDR && !soft_reset_reg) |=>
            O_OUTPUT_CLOCK_PHASE == $past(wr_data[2:1]))
        else $error("phase field not taken from bits 2-1");

endmodule : adc_mode_control_regs_low

`default_nettype wire

/* File: include/adc_mode_regs_pkg.sv */
package adc_mode_regs_pkg;

    // ------------------------------------------------------------
    // Serial frame layout
    // ------------------------------------------------------------
    localparam int FRAME_BITS = 16;
    localparam int HEADER_BITS = 8;
    localparam int ADDR_BITS = 7;
    localparam int DATA_BITS = 8;
    localparam int RW_POS = 15;
    localparam int SYNC_STAGES = 3;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [6:0] SOFT_RESET_CTRL_ADDR = 7'h00;
    localparam logic [6:0] CONVERTER_CTRL_ADDR = 7'h01;
    localparam logic [6:0] UNUSED_SLOT_ADDR = 7'h02;
    localparam logic [6:0] CLOCK_CTRL_ADDR = 7'h03;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SOFT_RESET_POS = 7;
    localparam int FRONT_END_GAIN_SELECT_POS = 3;
    localparam int DITHER_DISABLE_POS = 2;
    localparam int POWER_DOWN_POS = 1;
    localparam int ENCODE_TERM_ENABLE_POS = 5;
    localparam int KEEP_ALIVE_OSC_DISABLE_POS = 4;
    localparam int OUTPUT_CLOCK_INVERT_POS = 3;
    localparam int OUTPUT_CLOCK_PHASE_HI = 2;
    localparam int OUTPUT_CLOCK_PHASE_LO = 1;
    localparam int DUTY_CYCLE_STABILIZER_POS = 0;

    // ------------------------------------------------------------
    // Implemented bit masks and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CONVERTER_CTRL_MASK = 8'h0e;
    localparam logic [7:0] CLOCK_CTRL_MASK = 8'h3f;
    localparam logic [7:0] UNUSED_SLOT_VALUE = 8'h00;
    localparam logic [7:0] CONVERTER_CTRL_RESET = 8'h00;
    localparam logic [7:0] CLOCK_CTRL_RESET = 8'h00;
    localparam logic [4:0] BIT_CNT_RESET = 5'h00;

endpackage : adc_mode_regs_pkg

/* File: rtl/input_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module input_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Raw and filtered levels
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_level
);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            logic meta_reg;
            logic stage2_reg;
            logic stage3_reg;
            logic level_reg;

            always_ff @(posedge i_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    meta_reg <= RESET_VAL[g];
                    stage2_reg <= RESET_VAL[g];
                    stage3_reg <= RESET_VAL[g];
                end else begin
                    meta_reg <= i_async[g];
                    stage2_reg <= meta_reg;
                    stage3_reg <= stage2_reg;
                end
            end

            // Change accepted once stages two and three agree
            always_ff @(posedge i_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    level_reg <= RESET_VAL[g];
                end else if (stage2_reg == stage3_reg) begin
                    level_reg <= stage3_reg;
                end
            end

            assign o_level[g] = level_reg;
        end
    endgenerate

endmodule : input_sync

`default_nettype wire

/* File: verification/spi_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
    // Serial port
    output logic o_cs_n,
    output logic o_sck,
    output logic o_sdi,
    input wire logic i_sdo
);
    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_sdi = 1'b0;
    end

    // ------------------------------------------------------------
    // One frame of nbits; read data shifted in after the header
    // ------------------------------------------------------------
    task automatic xfer(input logic rw, input logic [6:0] addr,
                        input logic [7:0] data, input int nbits,
                        output logic [7:0] rdata);
        logic [15:0] word;
        word = {rw, addr, data};
        rdata = 8'h00;
        #1.7;
        o_cs_n = 1'b0;
        #32;
        for (int i = 0; i < nbits; i++) begin
            o_sdi = word[15 - (i % 16)];
            #32;
            o_sck = 1'b1;
            if (i >= 8 && i < 16) begin
                rdata = {rdata[6:0], i_sdo};
            end
            #32;
            o_sck = 1'b0;
        end
        #32;
        o_cs_n = 1'b1;
        // Released line must not hold a stale value
        o_sdi = ~o_sdi;
        #64;
    endtask : xfer
endmodule : spi_host_model

`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import adc_mode_regs_pkg::*;

    logic clk = 1'b0;
    logic arst_n;
    logic cs_n, sck, sdi, sdo_out, sdo_oe, sdo_wire;
    logic gain, dither_disable, pdn, enc, kao, inv, duty_cycle_stabilizer_enable;
    logic [1:0] phase;
    logic [7:0] exp_reg [4];
    int error_cnt = 0;
    int cmp_count = 0;

    always #2.5 clk = ~clk;
    // Open-drain line with pull-up
    assign sdo_wire = sdo_oe ? 1'b0 : 1'b1;

    adc_mode_control_regs_low adc_mode_control_regs_low_inst (
        .I_CLK(clk), .I_ARST_N(arst_n), .I_CS_N(cs_n), .I_SCK(sck),
        .I_SDI(sdi), .O_SDO_OUT(sdo_out), .O_SDO_OE(sdo_oe),
        .O_FRONT_END_GAIN_SELECT(gain), .O_DITHER_DISABLE(dither_disable),
        .O_POWER_DOWN(pdn), .O_ENCODE_TERM_ENABLE(enc),
        .O_KEEP_ALIVE_OSC_DISABLE(kao), .O_OUTPUT_CLOCK_INVERT(inv),
        .O_OUTPUT_CLOCK_PHASE(phase),
        .O_DUTY_CYCLE_STABILIZER_ENABLE(duty_cycle_stabilizer_enable));

    spi_host_model spi_host_model_inst (
        .o_cs_n(cs_n), .o_sck(sck), .o_sdi(sdi), .i_sdo(sdo_wire));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    function automatic logic [7:0] mask_of(input logic [6:0] addr);
        case (addr)
            CONVERTER_CTRL_ADDR: return CONVERTER_CTRL_MASK;
            CLOCK_CTRL_ADDR: return CLOCK_CTRL_MASK;
            default: return 8'h00;
        endcase
    endfunction : mask_of

    // Write frame, update the expected image, let the update land
    task automatic wr(input logic [6:0] addr, input logic [7:0] data);
        logic [7:0] rd;
        spi_host_model_inst.xfer(1'b0, addr, data, 16, rd);
        if (addr == SOFT_RESET_CTRL_ADDR && data[7]) begin
            exp_reg = '{default: 8'h00};
        end else if (addr < 7'h04) begin
            exp_reg[addr[1:0]] = data & mask_of(addr);
        end
        repeat (10) @(negedge clk);
    endtask : wr

    // Read frame with random data on the input line
    task automatic rd_chk(input logic [6:0] addr);
        logic [7:0] rd;
        spi_host_model_inst.xfer(1'b1, addr, 8'($urandom), 16, rd);
        check("readback", rd,
              (addr < 7'h04) ? exp_reg[addr[1:0]] : 8'h00);
        repeat (10) @(negedge clk);
    endtask : rd_chk

    task automatic chk_out();
        check("converter pins", {4'h0, gain, dither_disable, pdn, 1'b0},
              exp_reg[1]);
        check("clock pins", {2'h0, enc, kao, inv, phase, duty_cycle_stabilizer_enable},
              exp_reg[3]);
        check("sdo pins", {6'h00, sdo_oe, sdo_out}, 8'h00);
    endtask : chk_out

    initial begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        $display("CHECK FAILED run length expected end seen timeout");
        give_verdict();
    end

    initial begin
        logic [6:0] a;
        logic [7:0] rd;
        logic [7:0] d;
        logic [6:0] odd_addr [3];
        odd_addr = '{7'h02, 7'h04, 7'h7f};
        arst_n = 1'b0;
        exp_reg = '{default: 8'h00};
        void'($urandom(9));
        repeat (16) @(negedge clk);
        arst_n = 1'b1;
        repeat (5) @(negedge clk);
        chk_out();
        rd_chk(CONVERTER_CTRL_ADDR);
        rd_chk(CLOCK_CTRL_ADDR);
        $display("test reset_values done");

        for (int i = 0; i < 24; i++) begin
            a = (i % 2) ? CLOCK_CTRL_ADDR : CONVERTER_CTRL_ADDR;
            d = (i < 2) ? 8'hff : 8'($urandom);
            // Host keeps the stabilizer on with any phase delay
            if (a == CLOCK_CTRL_ADDR && d[2:1] != 2'h0) begin
                d[0] = 1'b1;
            end
            wr(a, d);
            chk_out();
            rd_chk(a);
            chk_out();
        end
        $display("test random_writes done");

        for (int p = 0; p < 4; p++) begin
            wr(CLOCK_CTRL_ADDR, {5'h00, 2'(p), 1'b1});
            check("phase", {6'h00, phase}, 8'(p));
        end
        $display("test phase_codes done");

        wr(CONVERTER_CTRL_ADDR, 8'h0e);
        for (int k = 0; k < 3; k++) begin
            wr(odd_addr[k], 8'($urandom));
            chk_out();
            rd_chk(odd_addr[k]);
        end
        rd_chk(SOFT_RESET_CTRL_ADDR);
        wr(SOFT_RESET_CTRL_ADDR, 8'h7f);
        chk_out();
        $display("test unused_places done");

        spi_host_model_inst.xfer(1'b0, CONVERTER_CTRL_ADDR, 8'h00, 12, rd);
        repeat (10) @(negedge clk);
        chk_out();
        spi_host_model_inst.xfer(1'b0, CLOCK_CTRL_ADDR, 8'h15, 20, rd);
        exp_reg[3] = 8'h15;
        repeat (10) @(negedge clk);
        chk_out();
        $display("test frame_length done");

        wr(SOFT_RESET_CTRL_ADDR, 8'h80);
        chk_out();
        rd_chk(SOFT_RESET_CTRL_ADDR);
        wr(CONVERTER_CTRL_ADDR, 8'h08);
        chk_out();
        $display("test soft_reset done");

        wr(CLOCK_CTRL_ADDR, 8'h3f);
        @(negedge clk);
        arst_n = 1'b0;
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        exp_reg = '{default: 8'h00};
        repeat (5) @(negedge clk);
        chk_out();
        rd_chk(CLOCK_CTRL_ADDR);
        $display("test async_reset done");
        give_verdict();
    end
endmodule : testbench

`default_nettype wire
